// ==== hdl/tbpc_pkg.sv ====
package tbpc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_TIME_MS = 20;
  localparam int WDT_CYCLES = (WDT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WDT_W = 21;
  localparam int SW_PERIOD_CYC = 100;
  localparam int SHIFT_90_DIV = 4;
  localparam int SHIFT_45_DIV = 8;

  // ****************************************************************
  // Command word layout
  // ****************************************************************
  localparam int CMD_W = 12;
  localparam int CMD_SS_FAST_BIT = 10;
  localparam int CMD_KEEP_B_BIT = 9;
  localparam int CMD_CLK_EN_BIT = 8;
  localparam int CMD_CLK_45_BIT = 7;
  localparam int CODE_W = 7;
  localparam logic [CMD_W-1:0] CMD_RESET = 12'h000;

  // Target code is 2 x (Vout - 9 V)
  localparam logic [CODE_W-1:0] CODE_60V = 7'h66;
  localparam logic [CODE_W-1:0] CODE_36V = 7'h36;
  localparam logic [CODE_W-1:0] CODE_NONE = 7'h00;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_HALF = 2'h1,
    STRAP_RAIL = 2'h2,
    STRAP_RAIL_ALT = 2'h3
  } tbpc_strap_e;

  typedef enum logic [1:0] {
    RUN_OFF = 2'h0,
    RUN_WAIT = 2'h1,
    RUN_ON = 2'h3
  } tbpc_run_e;

endpackage

// ==== hdl/tbpc_sync.sv ====
module tbpc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// ==== hdl/tbpc_core.sv ====
// What this block does
// - Each phase latch is set by its clock pulse; gate high while set.
// - Sense comparator trip clears that phase latch, ending the pulse.
// - Phase B set pulse falls half a switching period after phase A.
// - Light-load drop flag sheds phase B.
// - Shed phase B resumes only on the resume flag or the held keep-B command bit, giving hysteresis.
// - Thermal shutdown, supply lockout or disable force both gates low.
// - Strap at rail: wake with 60 V code, reload it on watchdog expiry.
// - Strap at half or open: wake with 36 V code, reload on expiry.
// - Strap grounded: no watchdog; switching waits for a command after enable.
// - Power-ok pulls low when either window comparator trips.
// - Held command drives divider ratio and chain clock pin setup.
// - Chain clock output drives next device's sync input for multiphase.
// - Chain clock is 45 or 90 degrees after phase A, can float.
// - Watchdog restores strap default target without a command every 20 ms.
// - Target held as seven-bit code 2 x (Vout - 9 V), selects divider.
module tbpc_core #(
  parameter int PERIOD = tbpc_pkg::SW_PERIOD_CYC,
  parameter int WDT_CYCLES = tbpc_pkg::WDT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Analog comparators
  input wire logic sense_trip_a_in,
  input wire logic sense_trip_b_in,
  input wire logic light_drop_in,
  input wire logic light_resume_in,
  input wire logic window_high_in,
  input wire logic window_low_in,
  // Faults, enable, strap, sync
  input wire logic thermal_sd_in,
  input wire logic supply_uvlo_in,
  input wire logic enable_in,
  input wire logic [1:0] mode_strap_in,
  input wire logic sync_spread_input_in,
  // Checked command
  input wire logic cmd_valid_in,
  input wire logic [tbpc_pkg::CMD_W-1:0] cmd_word_in,
  // Gate drives
  output logic phase_a_drive_out,
  output logic phase_b_drive_out,
  // Power-ok open drain
  output logic power_ok_flag_out,
  output logic power_ok_flag_oe_out,
  // Chain clock
  output logic chain_clock_output_out,
  output logic chain_clock_oe_out,
  // Held settings
  output logic [tbpc_pkg::CODE_W-1:0] divider_code_out,
  output logic soft_start_fast_out
);

  localparam int CNT_W = $clog2(PERIOD) + 1;
  localparam logic [CNT_W-1:0] PER_C = CNT_W'(PERIOD);
  localparam logic [CNT_W-1:0] LAST_C = CNT_W'(PERIOD - 1);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(PERIOD / 2);
  localparam logic [CNT_W-1:0] Q90_C =
    CNT_W'(PERIOD / tbpc_pkg::SHIFT_90_DIV);
  localparam logic [CNT_W-1:0] Q45_C =
    CNT_W'(PERIOD / tbpc_pkg::SHIFT_45_DIV);
  localparam logic [tbpc_pkg::WDT_W-1:0] WDT_LAST_C =
    tbpc_pkg::WDT_W'(WDT_CYCLES - 1);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [9:0] raw_w;
  logic [9:0] syn_w;
  logic trip_a_s, trip_b_s, drop_s, resume_s, win_hi_s, win_lo_s;
  logic thermal_s, uvlo_s, enable_s, sync_s;

  assign raw_w = {sense_trip_a_in, sense_trip_b_in, light_drop_in,
                  light_resume_in, window_high_in, window_low_in,
                  thermal_sd_in, supply_uvlo_in, enable_in,
                  sync_spread_input_in};

  tbpc_sync #(.WIDTH(10)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_w),
    .sync_out(syn_w)
  );

  assign {trip_a_s, trip_b_s, drop_s, resume_s, win_hi_s, win_lo_s,
          thermal_s, uvlo_s, enable_s, sync_s} = syn_w;

  function automatic logic [tbpc_pkg::CODE_W-1:0] strap_code(
    input tbpc_pkg::tbpc_strap_e s
  );
    case (s)
      tbpc_pkg::STRAP_GND: strap_code = tbpc_pkg::CODE_NONE;
      tbpc_pkg::STRAP_HALF: strap_code = tbpc_pkg::CODE_36V;
      default: strap_code = tbpc_pkg::CODE_60V;
    endcase
  endfunction

  // ****************************************************************
  // Switching timebase and chain clock
  // ****************************************************************
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic sync_d_r, sync_d_nxt;
  logic chain_r, chain_nxt;
  logic chain_oe_r, chain_oe_nxt;
  logic [CNT_W-1:0] shift_w, pos_w;
  logic [tbpc_pkg::CMD_W-1:0] cfg_r, cfg_nxt;

  always_comb begin
    sync_d_nxt = sync_s;
    if (sync_s && !sync_d_r) begin
      cnt_nxt = '0;
    end else if (cnt_r >= LAST_C) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    shift_w = cfg_r[tbpc_pkg::CMD_CLK_45_BIT] ? Q45_C : Q90_C;
    if (cnt_r >= shift_w) begin
      pos_w = cnt_r - shift_w;
    end else begin
      pos_w = cnt_r + (PER_C - shift_w);
    end
    chain_nxt = (pos_w < HALF_C);
    chain_oe_nxt = cfg_r[tbpc_pkg::CMD_CLK_EN_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      sync_d_r <= 1'b0;
      chain_r <= 1'b0;
      chain_oe_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sync_d_r <= sync_d_nxt;
      chain_r <= chain_nxt;
      chain_oe_r <= chain_oe_nxt;
    end
  end

  // ****************************************************************
  // Strap, command, watchdog, run state and shedding
  // ****************************************************************
  tbpc_pkg::tbpc_run_e state_r, state_nxt;
  tbpc_pkg::tbpc_strap_e strap_r, strap_nxt;
  logic strap_ok_r, strap_ok_nxt;
  logic [tbpc_pkg::CODE_W-1:0] target_r, target_nxt;
  logic target_ok_r, target_ok_nxt;
  logic [tbpc_pkg::WDT_W-1:0] wdt_r, wdt_nxt;
  logic expire_w, blocked_w, gnd_w;
  logic shed_r, shed_nxt;
  logic pok_r, pok_nxt;

  always_comb begin
    strap_ok_nxt = 1'b1;
    strap_nxt = strap_ok_r ? strap_r : tbpc_pkg::tbpc_strap_e'(mode_strap_in);
    gnd_w = (strap_r == tbpc_pkg::STRAP_GND);
    cfg_nxt = cfg_r;
    target_nxt = target_r;
    target_ok_nxt = target_ok_r;
    expire_w = 1'b0;
    wdt_nxt = wdt_r;
    if (!strap_ok_r) begin
      target_nxt = strap_code(strap_nxt);
    end else if (cmd_valid_in) begin
      cfg_nxt = cmd_word_in;
      target_nxt = cmd_word_in[tbpc_pkg::CODE_W-1:0];
      target_ok_nxt = 1'b1;
    end else begin
      if (gnd_w && !enable_s) begin
        target_ok_nxt = 1'b0;
      end
      if (!gnd_w && wdt_r >= WDT_LAST_C) begin
        expire_w = 1'b1;
        target_nxt = strap_code(strap_r);
      end
    end
    if (cmd_valid_in || gnd_w || expire_w || !strap_ok_r) begin
      wdt_nxt = '0;
    end else begin
      wdt_nxt = wdt_r + 1'b1;
    end
    blocked_w = thermal_s || uvlo_s || !enable_s || !strap_ok_r;
    state_nxt = state_r;
    case (state_r)
      tbpc_pkg::RUN_OFF: begin
        if (!blocked_w) begin
          state_nxt = (gnd_w && !target_ok_r) ? tbpc_pkg::RUN_WAIT
                                              : tbpc_pkg::RUN_ON;
        end
      end
      tbpc_pkg::RUN_WAIT: begin
        if (blocked_w) begin
          state_nxt = tbpc_pkg::RUN_OFF;
        end else if (target_ok_r) begin
          state_nxt = tbpc_pkg::RUN_ON;
        end
      end
      default: begin
        if (blocked_w) begin
          state_nxt = tbpc_pkg::RUN_OFF;
        end
      end
    endcase
    if (cfg_r[tbpc_pkg::CMD_KEEP_B_BIT] || resume_s) begin
      shed_nxt = 1'b0;
    end else if (drop_s) begin
      shed_nxt = 1'b1;
    end else begin
      shed_nxt = shed_r;
    end
    pok_nxt = !(win_hi_s || win_lo_s);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= tbpc_pkg::RUN_OFF;
      strap_r <= tbpc_pkg::STRAP_GND;
      strap_ok_r <= 1'b0;
      cfg_r <= tbpc_pkg::CMD_RESET;
      target_r <= tbpc_pkg::CODE_NONE;
      target_ok_r <= 1'b0;
      wdt_r <= '0;
      shed_r <= 1'b0;
      pok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      strap_r <= strap_nxt;
      strap_ok_r <= strap_ok_nxt;
      cfg_r <= cfg_nxt;
      target_r <= target_nxt;
      target_ok_r <= target_ok_nxt;
      wdt_r <= wdt_nxt;
      shed_r <= shed_nxt;
      pok_r <= pok_nxt;
    end
  end

  // ****************************************************************
  // Phase latches
  // ****************************************************************
  logic run_w, set_a_w, set_b_w;
  logic gate_a_r, gate_a_nxt, gate_b_r, gate_b_nxt;

  always_comb begin
    run_w = (state_r == tbpc_pkg::RUN_ON);
    set_a_w = run_w && (cnt_r == '0);
    set_b_w = run_w && !shed_r && (cnt_r == HALF_C);
    if (!run_w || trip_a_s) begin
      gate_a_nxt = 1'b0;
    end else if (set_a_w) begin
      gate_a_nxt = 1'b1;
    end else begin
      gate_a_nxt = gate_a_r;
    end
    if (!run_w || shed_r || trip_b_s) begin
      gate_b_nxt = 1'b0;
    end else if (set_b_w) begin
      gate_b_nxt = 1'b1;
    end else begin
      gate_b_nxt = gate_b_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gate_a_r <= 1'b0;
      gate_b_r <= 1'b0;
    end else begin
      gate_a_r <= gate_a_nxt;
      gate_b_r <= gate_b_nxt;
    end
  end

  assign phase_a_drive_out = gate_a_r;
  assign phase_b_drive_out = gate_b_r;
  assign power_ok_flag_out = 1'b0;
  assign power_ok_flag_oe_out = !pok_r;
  assign chain_clock_output_out = chain_r;
  assign chain_clock_oe_out = chain_oe_r;
  assign divider_code_out = target_r;
  assign soft_start_fast_out = cfg_r[tbpc_pkg::CMD_SS_FAST_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_set_a;
    set_a_w && !trip_a_s;
  endsequence
  sequence s_trip_a;
    trip_a_s;
  endsequence

  latch_set_a: assert property (s_set_a |=> phase_a_drive_out)
    else $error("phase A not set by its clock");
  latch_clear_a: assert property (s_trip_a |=> !phase_a_drive_out)
    else $error("phase A not cleared by trip");
  phase_spacing_a: assert property (
    $rose(phase_b_drive_out) |-> $past(cnt_r) == HALF_C)
    else $error("phase B not half a period after A");
  shed_stop_a: assert property (shed_r |=> !phase_b_drive_out)
    else $error("shed phase B still switching");
  shed_resume_a: assert property (
    $fell(shed_r) |-> $past(resume_s) ||
      $past(cfg_r[tbpc_pkg::CMD_KEEP_B_BIT]))
    else $error("phase B resumed without resume flag");
  fault_low_a: assert property (
    (thermal_s || uvlo_s || !enable_s) |=> ##1
      (!phase_a_drive_out && !phase_b_drive_out))
    else $error("gate high during fault");
  reload_60_a: assert property (
    expire_w && strap_r == tbpc_pkg::STRAP_RAIL |=>
      divider_code_out == tbpc_pkg::CODE_60V)
    else $error("60 V code not reloaded");
  reload_36_a: assert property (
    expire_w && strap_r == tbpc_pkg::STRAP_HALF |=>
      divider_code_out == tbpc_pkg::CODE_36V)
    else $error("36 V code not reloaded");
  hold_nocmd_a: assert property (
    strap_ok_r && gnd_w && !target_ok_r |=> !run_w)
    else $error("switching without command in grounded mode");
  power_ok_a: assert property (
    (win_hi_s || win_lo_s) |=> power_ok_flag_oe_out)
    else $error("power-ok not pulled low");
  code_load_a: assert property (
    strap_ok_r && cmd_valid_in |=>
      divider_code_out == $past(cmd_word_in[tbpc_pkg::CODE_W-1:0]))
    else $error("target code not taken from command");

endmodule

// ==== test/tbpc_stage_model.sv ====
module tbpc_stage_model (
  // Clock
  input wire logic clk_in,
  // Gate drives and ramp speed
  input wire logic gate_a_in,
  input wire logic gate_b_in,
  input wire logic slow_in,
  // Current comparator trips
  output logic trip_a_out,
  output logic trip_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ramp_a_r;
  logic [3:0] ramp_b_r;
  logic [3:0] limit;

  // Inductor current ramps only while its switch is on
  assign limit = slow_in ? 4'h5 : 4'h2;
  always_ff @(posedge clk_in) begin
    ramp_a_r <= gate_a_in ? ramp_a_r + 4'h1 : 4'h0;
    ramp_b_r <= gate_b_in ? ramp_b_r + 4'h1 : 4'h0;
  end
  assign trip_a_out = gate_a_in && (ramp_a_r >= limit);
  assign trip_b_out = gate_b_in && (ramp_b_r >= limit);
endmodule

// ==== test/tbpc_core_tb.sv ====
module tbpc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 16;
  localparam int WD = 200;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic drop, resume, win_hi, win_lo, hot, uvlo, en, slow, cmd_v;
  logic trip_a, trip_b, ga, gb, pok, pok_oe, ck, ck_oe, fast;
  logic pa, pb, pc, sy;
  logic [1:0] strap;
  logic [6:0] code;
  logic [11:0] cmd_w, cyc, na, nb, ha, hf, ta, tbr, tc;
  int errors = 0;
  int n_checks = 0;

  always #5 clk_in = ~clk_in;

  tbpc_core #(.PERIOD(P), .WDT_CYCLES(WD)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .sense_trip_a_in(trip_a), .sense_trip_b_in(trip_b),
    .light_drop_in(drop), .light_resume_in(resume),
    .window_high_in(win_hi), .window_low_in(win_lo),
    .thermal_sd_in(hot), .supply_uvlo_in(uvlo), .enable_in(en),
    .mode_strap_in(strap), .sync_spread_input_in(sy),
    .cmd_valid_in(cmd_v), .cmd_word_in(cmd_w),
    .phase_a_drive_out(ga), .phase_b_drive_out(gb),
    .power_ok_flag_out(pok), .power_ok_flag_oe_out(pok_oe),
    .chain_clock_output_out(ck), .chain_clock_oe_out(ck_oe),
    .divider_code_out(code), .soft_start_fast_out(fast));

  tbpc_stage_model i_stage (.clk_in(clk_in), .gate_a_in(ga),
    .gate_b_in(gb), .slow_in(slow), .trip_a_out(trip_a),
    .trip_b_out(trip_b));

  // ****************************************
  // Edge and on-time counters
  // ****************************************
  always @(negedge clk_in) begin
    cyc++;
    na += 12'(ga && !pa);
    nb += 12'(gb && !pb);
    ha += 12'(ga);
    ta = (ga && !pa) ? cyc : ta;
    tbr = (gb && !pb) ? cyc : tbr;
    tc = (ck && !pc) ? cyc : tc;
    {pa, pb, pc} = {ga, gb, ck};
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Counts over exactly n cycles, ends on a rising edge
  task automatic span(input int n);
    @(posedge clk_in);
    {na, nb, ha} = '0;
    repeat (n) @(posedge clk_in);
  endtask

  task automatic send(input logic [11:0] w);
    cmd_w = w;
    cmd_v = 1'b1;
    tick(1);
    cmd_v = 1'b0;
    tick(3);
  endtask

  task automatic boot(input logic [1:0] s);
    tick(1);
    en = 1'b0;
    strap = s;
    rst_n_in = 1'b0;
    tick(3);
    chk(12'({ga, gb, pok_oe}), 12'h001);
    rst_n_in = 1'b1;
    tick(3);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    results();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {drop, resume, win_hi, win_lo, hot, uvlo, en, slow, cmd_v} = '0;
    {pa, pb, pc, sy, strap} = '0;
    {cmd_w, cyc, na, nb, ha, hf, ta, tbr, tc} = '0;
    boot(2'h2);
    chk(12'(code), 12'(tbpc_pkg::CODE_60V));
    en = 1'b1;
    span(P);
    span(4 * P);
    chk(na, 12'h004);
    chk(nb, 12'h004);
    chk((tbr - ta) & 12'h00F, 12'(P / 2));
    hf = ha;
    tick(1);
    slow = 1'b1;
    span(P);
    span(4 * P);
    chk(ha - hf, 12'h00C);
    tick(1);
    slow = 1'b0;
    $display("test switching done");
    send(12'h5CE);
    chk(12'({code, fast, ck_oe}), 12'h13B);
    span(2 * P);
    chk((tc - ta) & 12'h00F, 12'(P / 8));
    tick(1);
    send(12'h14E);
    span(2 * P);
    chk((tc - ta) & 12'h00F, 12'(P / 4));
    chk(12'(fast), 12'h000);
    tick(1);
    send(12'h04E);
    chk(12'(ck_oe), 12'h000);
    tick(WD - 20);
    chk(12'(code), 12'h04E);
    tick(30);
    chk(12'(code), 12'(tbpc_pkg::CODE_60V));
    $display("test command done");
    drop = 1'b1;
    tick(4);
    drop = 1'b0;
    span(P);
    span(4 * P);
    chk(na, 12'h004);
    chk(nb, 12'h000);
    tick(1);
    resume = 1'b1;
    tick(4);
    resume = 1'b0;
    span(P);
    span(4 * P);
    chk(nb, 12'h004);
    tick(1);
    send(12'h24E);
    drop = 1'b1;
    span(P);
    span(4 * P);
    chk(nb, 12'h004);
    tick(1);
    drop = 1'b0;
    $display("test shed done");
    for (int i = 0; i < 3; i++) begin
      hot = (i == 0);
      uvlo = (i == 1);
      en = (i != 2);
      span(P);
      span(2 * P);
      chk(na + nb + ha, 12'h000);
      tick(1);
    end
    {hot, uvlo, en} = 3'b001;
    for (int i = 0; i < 4; i++) begin
      {win_hi, win_lo} = 2'(i);
      tick(4);
      chk(12'({pok_oe, pok}), 12'({i != 0, 1'b0}));
    end
    {win_hi, win_lo} = 2'h0;
    // Sync edges every 12 cycles restart the timebase early
    repeat (4) begin
      sy = 1'b1;
      tick(1);
      sy = 1'b0;
      tick(11);
    end
    @(posedge clk_in);
    chk(cyc - ta, 12'h008);
    $display("test faults done");
    boot(2'h0);
    en = 1'b1;
    span(4 * P);
    chk(na + nb, 12'h000);
    tick(1);
    send(12'h020);
    span(P);
    span(4 * P);
    chk(na, 12'h004);
    tick(WD + 20);
    chk(12'(code), 12'h020);
    boot(2'h1);
    chk(12'(code), 12'(tbpc_pkg::CODE_36V));
    send(12'h04E);
    chk(12'(code), 12'h04E);
    tick(WD + 10);
    chk(12'(code), 12'(tbpc_pkg::CODE_36V));
    $display("test strap done");
    results();
  end
endmodule
